// ===== pot_defs.vh
/*
 * Shared constants of the four-channel pot control block: channel count,
 * serial state codes, operation codes and preset layout.
 * Assumes inclusion by bare name from each design file that needs it.
 */
`ifndef POT_DEFS_VH
`define POT_DEFS_VH

`define CHANNELS        4
`define POS_W           8
`define POS_MAX         8'hff
`define POS_MIN         8'h00
`define PRESET_INIT     8'h80
`define PRESET_AW       4
`define PRESET_DEPTH    16

// Serial slave states
`define ST_IDLE         3'h0
`define ST_ADDR         3'h1
`define ST_INSTR        3'h2
`define ST_DATA_W       3'h3
`define ST_READ         3'h4

// Instruction byte: [7:4] operation, [3:2] channel, [1:0] preset slot
`define OP_RD_WCR       4'h9
`define OP_WR_WCR       4'ha
`define OP_RD_PRE       4'hb
`define OP_WR_PRE       4'hc
`define OP_XFER_TO_WCR  4'hd
`define OP_XFER_TO_PRE  4'he

`define BIT_ACK         4'h8
`define INIT_DONE       3'h5

`endif

// ===== preset_mem.v
/*
 * Preset store: sixteen bytes, four per channel, one write port and one
 * read port whose data come out of a register.
 * Assumes a single clock; contents start at a fixed value after reset.
 */
`timescale 1ns/10ps
`include "pot_defs.vh"

module preset_mem #(
    parameter AW = `PRESET_AW,
    parameter DW = `POS_W
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire          ce,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);

    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer      i;

    // Non-volatile contents are modelled as a reset value
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem[i] <= `PRESET_INIT;
            end
            rdata <= {DW{1'b0}};
        end else if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end

endmodule // preset_mem

// ===== pot_control.v
/*
 * Control logic of a four-channel digital potentiometer: wiper position
 * registers, preset store, a 2-wire serial slave and an up/down stepper.
 * Assumes scl, sda and every control pin arrive asynchronously and are
 * far slower than clk; the sda wire is resolved outside from sda_oe.
 */
// Contract
// - Four channels, one position, four presets each
// - Position is an 8-bit tap code
// - Reset copies first preset into each position
// - Serial data sampled on rising scl
// - Returned data changes after falling scl
// - Data line only pulled low or released
// - Respond only when address matches straps
// - Serial write, read and transfer operations
// - Scl serves serial and up/down by select
// - Select low lets scl step the wiper
// - Serial slave active only while select high
// - Channel pick chooses the stepped channel
// - Write protect low blocks every preset write
`timescale 1ns/10ps
`include "pot_defs.vh"

module pot_control #(
    parameter [4:0] SLAVE_ID = 5'h0a  // Arbitrary upper address bits
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        ce,
    input  wire        scl,
    input  wire        sda_in,
    output wire        sda_out,
    output reg         sda_oe,
    input  wire        cs_n,
    input  wire        up_dn,
    input  wire [1:0]  channel_pick,
    input  wire [2:0]  addr_strap,
    input  wire        wp_n,
    output wire [31:0] wiper_position_reg,
    output wire        busy
);

    ////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers, then one delay stage for edges
    reg  [9:0] sync1;
    reg  [9:0] sync2;
    reg        scl_d;
    reg        sda_d;
    reg        cs_n_d;
    wire       scl_s  = sync2[0];
    wire       sda_s  = sync2[1];
    wire       cs_n_s = sync2[2];
    wire       up_s   = sync2[3];
    wire [1:0] pick_s = sync2[5:4];
    wire [2:0] strap_s = sync2[8:6];
    wire       wp_n_s = sync2[9];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1  <= 10'h3ff;
            sync2  <= 10'h3ff;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
            cs_n_d <= 1'b1;
        end else if (ce) begin
            sync1  <= {wp_n, addr_strap, channel_pick, up_dn, cs_n, sda_in, scl};
            sync2  <= sync1;
            scl_d  <= scl_s;
            sda_d  <= sda_s;
            cs_n_d <= cs_n_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire serial_on = cs_n_s & ~busy;
    wire start_c = serial_on & scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c  = serial_on & scl_s & scl_d & ~sda_d & sda_s;
    wire updn_on = ~cs_n_s & ~busy;

    ////////////////////////////////////////////////////////////////////
    // Power-up recall sequencer
    reg  [2:0] init_step;
    assign busy = (init_step != `INIT_DONE);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_step <= 3'h0;
        end else if (ce && busy) begin
            init_step <= init_step + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial slave
    reg  [2:0] state;
    reg  [3:0] bit_cnt;
    reg  [7:0] shift;
    reg  [7:0] instr;
    reg  [7:0] rd_shift;
    reg  [3:0] ser_raddr;
    wire [7:0] mem_rdata;
    wire [7:0] wcr_sel;

    wire [3:0] op_now   = shift[7:4];
    wire       op_valid = (op_now >= `OP_RD_WCR) && (op_now <= `OP_XFER_TO_PRE);
    wire       addr_hit = (shift[7:3] == SLAVE_ID) && (shift[2:0] == strap_s);
    wire       ack_rise = serial_on & scl_rise & (bit_cnt == `BIT_ACK);
    wire       wr_wcr   = ack_rise & (state == `ST_DATA_W) & (instr[7:4] == `OP_WR_WCR);
    wire       xf_wcr   = ack_rise & (state == `ST_INSTR) & (op_now == `OP_XFER_TO_WCR);
    wire       wr_pre   = ack_rise & (state == `ST_DATA_W) & (instr[7:4] == `OP_WR_PRE);
    wire       xf_pre   = ack_rise & (state == `ST_INSTR) & (op_now == `OP_XFER_TO_PRE);
    wire [1:0] ser_ch   = (state == `ST_INSTR) ? shift[3:2] : instr[3:2];
    wire [3:0] ser_slot = (state == `ST_INSTR) ? shift[3:0] : instr[3:0];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= `ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            instr     <= 8'h00;
            rd_shift  <= 8'h00;
            ser_raddr <= 4'h0;
            sda_oe    <= 1'b0;
        end else if (ce) begin
            if (!serial_on || stop_c) begin
                state  <= `ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_c) begin
                state   <= `ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (scl_rise && state != `ST_IDLE) begin
                if (bit_cnt != `BIT_ACK) begin
                    shift   <= {shift[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end else begin
                    bit_cnt <= 4'h0;
                    case (state)
                        `ST_ADDR: begin
                            state <= addr_hit ? `ST_INSTR : `ST_IDLE;
                        end
                        `ST_INSTR: begin
                            instr <= shift;
                            if (op_now == `OP_WR_WCR || op_now == `OP_WR_PRE) begin
                                state <= `ST_DATA_W;
                            end else if (op_now == `OP_RD_WCR) begin
                                state    <= `ST_READ;
                                rd_shift <= wcr_sel;
                            end else if (op_now == `OP_RD_PRE) begin
                                state    <= `ST_READ;
                                rd_shift <= mem_rdata;
                            end else begin
                                state <= `ST_IDLE;
                            end
                        end
                        `ST_READ: begin
                            // Master acknowledge repeats the same byte
                            state <= sda_s ? `ST_IDLE : `ST_READ;
                        end
                        default: begin
                            state <= `ST_IDLE;
                        end
                    endcase
                end
            end else if (scl_fall) begin
                // Drive changes only while scl is low; idle too, so a final ack is let go
                if (bit_cnt == `BIT_ACK) begin
                    case (state)
                        `ST_ADDR:   sda_oe <= addr_hit;
                        `ST_INSTR: begin
                            sda_oe    <= op_valid;
                            ser_raddr <= shift[3:0];
                        end
                        `ST_DATA_W: sda_oe <= 1'b1;
                        default:    sda_oe <= 1'b0;
                    endcase
                end else if (state == `ST_READ) begin
                    sda_oe <= ~rd_shift[3'h7 - bit_cnt[2:0]];
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    assign sda_out = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Up/down stepping and store
    wire ud_step  = updn_on & scl_rise;
    wire ud_store = cs_n_s & ~cs_n_d & scl_s & ~busy;
    // A store sees select already high, yet must save the picked channel
    wire [1:0] sel_ch = (cs_n_s & ~ud_store) ? ser_ch : pick_s;

    assign wcr_sel = wiper_position_reg[sel_ch*8 +: 8];

    ////////////////////////////////////////////////////////////////////
    // Preset store and its single write port
    wire       mem_we = ((wr_pre | xf_pre) & cs_n_s | ud_store) & wp_n_s;
    wire [3:0] mem_waddr = ud_store ? {pick_s, 2'b00} : ser_slot;
    wire [7:0] mem_wdata = wr_pre ? shift : wcr_sel;
    wire [3:0] mem_raddr = busy ? {init_step[1:0], 2'b00} : ser_raddr;

    preset_mem #(
        .AW (`PRESET_AW),
        .DW (`POS_W)
    ) u_presets (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Wiper position registers, one per channel
    genvar g;
    generate
        for (g = 0; g < `CHANNELS; g = g + 1) begin : chan
            reg  [7:0] pos;
            wire       hit = (sel_ch == g);
            assign wiper_position_reg[g*8 +: 8] = pos;

            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    pos <= `POS_MIN;
                end else if (ce) begin
                    if (busy && init_step == g + 1) begin
                        pos <= mem_rdata;
                    end else if (wr_wcr && hit) begin
                        pos <= shift;
                    end else if (xf_wcr && hit) begin
                        pos <= mem_rdata;
                    end else if (ud_step && hit) begin
                        if (up_s && pos != `POS_MAX) begin
                            pos <= pos + 8'h01;
                        end else if (!up_s && pos != `POS_MIN) begin
                            pos <= pos - 8'h01;
                        end
                    end
                end
            end
        end
    endgenerate

endmodule // pot_control

// ===== pot_props.sv
/* Checker of the pot_control ports.
   Assumes ce held high and scl far slower than clk. */
`timescale 1ns/10ps
`include "pot_defs.vh"
module pot_props (
    input wire        clk,
    input wire        rstn,
    input wire        scl,
    input wire        sda_out,
    input wire        sda_oe,
    input wire        cs_n,
    input wire        up_dn,
    input wire [1:0]  channel_pick,
    input wire [31:0] wiper_position_reg,
    input wire        busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Only the picked lane moves, by one, and it never wraps
    function automatic bit step_ok(input [31:0] o, n, input d, input [1:0] c);
        logic [7:0] e;
        step_ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            e = d ? (o[8*i+:8] == 8'hff ? 8'hff : o[8*i+:8] + 8'h01)
                  : (o[8*i+:8] == 8'h00 ? 8'h00 : o[8*i+:8] - 8'h01);
            if (n[8*i+:8] != o[8*i+:8] && (i != c || n[8*i+:8] != e)) step_ok = 1'b0;
        end
    endfunction
    sequence steady_low;
        (!cs_n && !busy && $stable(up_dn) && $stable(channel_pick))[*6];
    endsequence
    drain_only_a: assert property (!sda_out)
        else $error("sda driven high");
    quiet_deselect_a: assert property ((!cs_n)[*5] |-> !sda_oe)
        else $error("sda pulled in step mode");
    ack_timing_a: assert property ($rose(sda_oe) |-> !scl && !$past(scl, 2))
        else $error("sda moved with scl high");
    ack_select_a: assert property ($rose(sda_oe) |-> cs_n && $past(cs_n, 4))
        else $error("sda pulled while deselected");
    recall_time_a: assert property ($rose(rstn) |-> ##[1:10] !busy)
        else $error("recall too long");
    recall_value_a: assert property ($fell(busy) |-> wiper_position_reg == {4{`PRESET_INIT}})
        else $error("recall value wrong");
    step_source_a: assert property (!$past(busy) && $changed(wiper_position_reg)
        |-> scl && $past(scl, 2)) else $error("position moved without scl");
    step_rule_a: assert property (steady_low
        |-> step_ok($past(wiper_position_reg), wiper_position_reg, up_dn, channel_pick))
        else $error("bad step");
endmodule // pot_props
////////////////////////////////////////
bind pot_control pot_props u_props (.clk(clk), .rstn(rstn), .scl(scl), .sda_out(sda_out),
    .sda_oe(sda_oe), .cs_n(cs_n), .up_dn(up_dn), .channel_pick(channel_pick),
    .wiper_position_reg(wiper_position_reg), .busy(busy));

// ===== pot_master.sv
/* Far side: 2-wire bus master and up/down controller.
   Assumes the bench resolves sda with a pull-up. */
`timescale 1ns/10ps
module pot_master (
    output reg       scl = 1'b1,
    output reg       sda_low = 1'b0,
    output reg       cs_n = 1'b1,
    output reg       up_dn = 1'b1,
    output reg [1:0] channel_pick = 2'h0,
    input  wire      sda
);
    // Whole clk periods only, so pins move just after a clk edge
    localparam int LEAD  = 30;  // scl fall to data change
    localparam int SETUP = 35;  // data change to scl rise
    localparam int HALF  = 60;  // scl high time
    localparam int LOW   = 65;  // scl low time
    // Data moves only in the low half of scl
    task automatic bit_io(input b, output s);
        #LEAD sda_low = !b;
        #SETUP scl = 1'b1;
        s = sda;
        #HALF scl = 1'b0;
    endtask
    task automatic start();
        #HALF sda_low = 1'b1;
        #LOW scl = 1'b0;
    endtask
    task automatic stop();
        #LEAD sda_low = 1'b1;
        #SETUP scl = 1'b1;
        #HALF sda_low = 1'b0;
        #LOW;
    endtask
    task automatic put(input [7:0] d, output a);
        reg s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        a = !s;
    endtask
    task automatic get(output [7:0] q); // Ends with a nack
        reg s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
        bit_io(1'b1, s);
    endtask
    task automatic step(input [1:0] c, input d);
        channel_pick = c;
        up_dn = d;
        #LOW scl = 1'b1;
        #HALF scl = 1'b0;
    endtask
    task automatic enter();
        scl = 1'b0;
        #LOW cs_n = 1'b0;
        #HALF;
    endtask
    // A store needs scl high, and that rise also steps
    task automatic leave(input store);
        #LOW scl = store;
        #HALF cs_n = 1'b1;
        #LOW scl = 1'b1;
        #HALF;
    endtask
endmodule // pot_master

// ===== tb.sv
/* Self-checking bench of pot_control with the master model.
   Assumes the defs header and the bound checker. */
`timescale 1ns/10ps
`include "pot_defs.vh"
module tb;
    localparam [4:0] ID = 5'h0a; // Arbitrary upper address bits
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg         wp_n = 1'b1;
    reg  [31:0] seed = 32'h02d74961;
    reg  [2:0]  strap = 3'h0;
    reg  [7:0]  want[4];
    reg  [7:0]  q;
    reg  [31:0] r;
    reg         a;
    wire        scl, sda_low, cs_n, up_dn, sda_oe, busy;
    wire [1:0]  pick;
    wire [31:0] pos;
    wire        sda = !(sda_low | sda_oe);
    int         err_total = 0, tests_run = 0, cyc = 0;
    pot_control #(.SLAVE_ID(ID)) DUT (.clk(clk), .rstn(rstn), .ce(1'b1), .scl(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .cs_n(cs_n), .up_dn(up_dn),
        .channel_pick(pick), .addr_strap(strap), .wp_n(wp_n),
        .wiper_position_reg(pos), .busy(busy));
    pot_master m (.scl(scl), .sda_low(sda_low), .cs_n(cs_n), .up_dn(up_dn),
        .channel_pick(pick), .sda(sda));
    initial forever #2.5 clk = !clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            wrap_up();
        end
    end
    ////////////////////////////////////////
    function automatic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic [7:0] sat(input [7:0] v, input up);
        return up ? (v == 8'hff ? v : v + 8'h01) : (v == 8'h00 ? v : v - 8'h01);
    endfunction
    task automatic check(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic set_wp(input v);
        @(posedge clk);
        #1 wp_n = v;
    endtask
    task automatic frame(input [2:0] id, input [3:0] op, input [3:0] arg, input [7:0] d);
        m.start();
        m.put({ID, id}, a);
        check("address ack", a, id == strap);
        if (a) begin
            m.put({op, arg}, a);
            if (op == `OP_WR_WCR || op == `OP_WR_PRE) m.put(d, a);
            if (op == `OP_RD_WCR || op == `OP_RD_PRE) m.get(q);
        end
        m.stop();
    endtask
    task automatic check_pos();
        repeat (8) @(posedge clk);
        #1 check("positions", pos, {want[3], want[2], want[1], want[0]});
    endtask
    initial begin
        r = rnd();
        strap = r[2:0];
        for (int i = 0; i < 4; i++) want[i] = `PRESET_INIT;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        wait (!busy);
        check_pos();
        for (int c = 0; c < 4; c++) begin
            r = rnd();
            want[c] = r[7:0];
            frame(strap, `OP_WR_WCR, {c[1:0], 2'h0}, want[c]);
            frame(strap, `OP_RD_WCR, {c[1:0], 2'h0}, 8'h00);
            check("position read", q, want[c]);
        end
        frame(strap ^ 3'h5, `OP_WR_WCR, 4'h0, 8'h00);
        check_pos();
        set_wp(1'b0);
        frame(strap, `OP_WR_PRE, 4'h6, 8'h3c);
        frame(strap, `OP_RD_PRE, 4'h6, 8'h00);
        check("protected preset", q, `PRESET_INIT);
        set_wp(1'b1);
        frame(strap, `OP_WR_PRE, 4'h6, 8'h3c);
        frame(strap, `OP_XFER_TO_WCR, 4'h6, 8'h00);
        want[1] = 8'h3c;
        check_pos();
        frame(strap, `OP_XFER_TO_PRE, 4'h3, 8'h00);
        frame(strap, `OP_RD_PRE, 4'h3, 8'h00);
        check("saved preset", q, want[0]);
        frame(strap, `OP_WR_WCR, 4'h8, 8'hfe);
        frame(strap, `OP_WR_WCR, 4'hc, 8'h01);
        want[2] = 8'hfe;
        want[3] = 8'h01;
        m.enter();
        for (int k = 0; k < 40; k++) begin
            r = rnd();
            if (k < 6) r[2:0] = k < 3 ? 3'h5 : 3'h6; // Push both ends first
            m.step(r[2:1], r[0]);
            want[r[2:1]] = sat(want[r[2:1]], r[0]);
        end
        m.leave(1'b0);
        check_pos();
        for (int w = 0; w < 2; w++) begin
            set_wp(w[0]);
            // Leave another channel in the last instruction before the store
            frame(strap, `OP_RD_WCR, {pick ^ 2'h1, 2'h0}, 8'h00);
            check("other position", q, want[pick ^ 2'h1]);
            m.enter();
            m.leave(1'b1);
            want[pick] = sat(want[pick], up_dn);
            frame(strap, `OP_RD_PRE, {pick, 2'h0}, 8'h00);
            check("stored preset", q, w ? want[pick] : `PRESET_INIT);
        end
        check_pos();
        wrap_up();
    end
endmodule // tb
